// ---- src/cib_can_core.sv ----
// CAN interrupt coding, timestamp counter, shared buffer RAM and registers
// Summary of operation
// - Highest-priority request shown as irq_source_code: error, then lowest buffer
// - Per-source enable bits suppress disabled interrupts
// - Any interrupt condition sets its pending flag
// - Writing one to irq_clear clears pending
// - Encoder skips requests without code enable
// - None 0/0, error 1/0, buffer n n+1
// - Free 16-bit counter counts bus bit times
// - ACK-slot count captured into buffer stamp word
// - Buffer 0 message captures then zeroes counter
// - Buffer-0 resync gated by timestamp_sync_enable
// - 144-word space: 16 banks, 16 control words
// - Shared RAM, contention stalls the loser
// - CPU word and byte access to RAM
// - Busy buffer blocks writes except status byte
// - Control registers answer without wait states
// - Fifteen fixed buffers of eight words each
// - Status word: length, reserved, priority, state
// - Engine buffer events raise buffer requests
`timescale 1ns/1ps
`default_nettype none
module cib_can_core (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire cib_pkg::cib_cpu_req_s cpuReq,
  output logic                       cpuAck,
  output logic [15:0]                cpuRData,
  input  wire cib_pkg::cib_eng_req_s engReq,
  output logic                       engAck,
  output logic [15:0]                engRData,
  input  wire logic                  bitTick,
  input  wire logic                  ackSlot,
  input  wire logic                  msgDone,
  input  wire logic [3:0]            msgBuf,
  input  wire logic                  bufIrq,
  input  wire logic [3:0]            bufIrqNum,
  input  wire logic                  errIrq,
  input  wire logic [15:0]           errCounters,
  input  wire logic [15:0]           errDiag,
  output cib_pkg::cib_cfg_s          cfgOut,
  output logic [15:0]                timestampCounter,
  output logic                       irqOut
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                             input logic [15:0] nw,
                                             input logic [1:0]  be);
    mergeBytes = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction : mergeBytes

  function automatic logic [7:0] wordIndex(input logic [19:0] a);
    logic [19:0] off;
    off = a - cib_pkg::CAN_BASE;
    wordIndex = off[8:1];
  endfunction : wordIndex

  function automatic logic atWord(input logic [19:0] a, input logic [19:0] r);
    atWord = a[19:1] == r[19:1];
  endfunction : atWord

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] ram [0:cib_pkg::BUF_CNT*cib_pkg::WORDS_PER_BUF-1];
  logic [15:0] statusW_r [0:cib_pkg::BUF_CNT-1];
  logic [15:0] stampW_r  [0:cib_pkg::BUF_CNT-1];
  logic [15:0] irqEnable_r;
  logic [15:0] irqPending_r;
  logic [15:0] irqPending_nxt;
  logic [15:0] irqCodeEn_r;
  logic [15:0] tsCount_r;
  logic [15:0] ackStamp_r;
  logic [3:0]  irqCode_r;
  logic        irqFlag_r;
  logic        lastCpu_r;
  logic        cpuAck_r;
  logic        engAck_r;
  logic [15:0] cpuRData_r;
  logic [15:0] engRData_r;
  cib_pkg::cib_cfg_s cfg_r;

  // ----------------------------------------
  // CPU address decode
  // ----------------------------------------
  wire logic [19:0] cpuOff   = cpuReq.addr - cib_pkg::CAN_BASE;
  wire logic        cpuHit   = cpuOff < 20'(2 * cib_pkg::SPACE_WORDS);
  wire logic [7:0]  cpuWord  = wordIndex(cpuReq.addr);
  wire logic [3:0]  cpuBank  = cpuWord[6:3];
  wire logic [2:0]  cpuSlot  = cpuWord[2:0];
  wire logic        cpuInBuf = !cpuWord[7] && cpuBank != 4'hf;
  wire logic        cpuTake  = cpuReq.valid && !cpuAck_r;
  wire logic        cpuRam   = cpuTake && cpuHit && cpuInBuf;
  wire logic        cpuRegs  = cpuTake && !(cpuHit && cpuInBuf);

  // ----------------------------------------
  // RAM arbitration, alternate on clash
  // ----------------------------------------
  // Alternating winner stops a steady engine from starving the CPU
  wire logic engTake = engReq.valid && !engAck_r;
  wire logic clash   = cpuRam && engTake;
  wire logic cpuWins = !clash || !lastCpu_r;
  wire logic engGo   = engTake && (!clash || lastCpu_r);
  wire logic cpuGo   = cpuRegs || (cpuRam && cpuWins);

  wire logic [3:0] engBank = engReq.addr[6:3];
  wire logic [2:0] engSlot = engReq.addr[2:0];
  wire logic       engInBuf = engBank != 4'hf;

  // ----------------------------------------
  // Busy protection of buffer contents
  // ----------------------------------------
  wire logic        cpuBusy   = statusW_r[cpuBank][cib_pkg::BUSY_BIT];
  wire logic        cpuIsStat = cpuSlot == cib_pkg::SLOT_STATUS_CONTROL;
  wire logic [1:0]  cpuBeEff  = (cpuBusy && !cpuIsStat) ? 2'b00 :
                                (cpuBusy ? {1'b0, cpuReq.byteEn[0]} :
                                 cpuReq.byteEn);
  wire logic        cpuWrRam  = cpuRam && cpuWins && cpuReq.write;
  wire logic        engWrRam  = engGo && engReq.write && engInBuf;

  // CPU cannot move the busy bit; only the engine owns it
  wire logic [15:0] cpuStatNew = mergeBytes(statusW_r[cpuBank], cpuReq.wdata, cpuBeEff);
  wire logic [15:0] cpuStatW   = {cpuStatNew[15:1],
                                  statusW_r[cpuBank][cib_pkg::BUSY_BIT]};

  // ----------------------------------------
  // Buffer read paths
  // ----------------------------------------
  wire logic [15:0] cpuBufRd =
    cpuIsStat ? statusW_r[cpuBank] :
    (cpuSlot == cib_pkg::SLOT_CAPTURE_TIME) ? stampW_r[cpuBank] :
    ram[{cpuBank, cpuSlot}];
  wire logic [15:0] engBufRd =
    !engInBuf ? 16'h0000 :
    (engSlot == cib_pkg::SLOT_STATUS_CONTROL) ? statusW_r[engBank] :
    (engSlot == cib_pkg::SLOT_CAPTURE_TIME) ? stampW_r[engBank] :
    ram[engReq.addr];

  // ----------------------------------------
  // Control register decode
  // ----------------------------------------
  wire logic [19:0] ra      = cpuReq.addr;
  wire logic        regWr   = cpuRegs && cpuHit && cpuReq.write;
  wire logic        hitGcfg = atWord(ra, cib_pkg::ADR_GLOBAL_CONFIGURATION);
  wire logic        hitTim  = atWord(ra, cib_pkg::ADR_BIT_TIMING_SETUP);
  wire logic        hitGmx  = atWord(ra, cib_pkg::ADR_GLB_MASK_EXT);
  wire logic        hitGmb  = atWord(ra, cib_pkg::ADR_GLB_MASK_BASE);
  wire logic        hitBmx  = atWord(ra, cib_pkg::ADR_BAS_MASK_EXT);
  wire logic        hitBmb  = atWord(ra, cib_pkg::ADR_BAS_MASK_BASE);
  wire logic        hitIen  = atWord(ra, cib_pkg::ADR_IRQ_ENABLE);
  wire logic        hitIpnd = atWord(ra, cib_pkg::ADR_IRQ_PENDING);
  wire logic        hitIclr = atWord(ra, cib_pkg::ADR_IRQ_CLEAR);
  wire logic        hitIcen = atWord(ra, cib_pkg::ADR_IRQ_CODE_ENABLE);
  wire logic        hitCode = atWord(ra, cib_pkg::ADR_STATUS_AND_IRQ_CODE);
  wire logic        hitErrc = atWord(ra, cib_pkg::ADR_ERROR_COUNTERS);
  wire logic        hitDiag = atWord(ra, cib_pkg::ADR_ERROR_DIAGNOSTIC);
  wire logic        hitTs   = atWord(ra, cib_pkg::ADR_TIMESTAMP_COUNTER);
  wire logic        wrGcfg  = regWr && hitGcfg;
  wire logic        wrTim   = regWr && hitTim;
  wire logic        wrGmx   = regWr && hitGmx;
  wire logic        wrGmb   = regWr && hitGmb;
  wire logic        wrBmx   = regWr && hitBmx;
  wire logic        wrBmb   = regWr && hitBmb;
  wire logic        wrIen   = regWr && hitIen;
  wire logic        wrIclr  = regWr && hitIclr;
  wire logic        wrIcen  = regWr && hitIcen;

  // Reserved and unmapped words read as zero; writes to them vanish
  wire logic [15:0] regRd =
    !cpuHit ? 16'h0000 :
    hitGcfg ? cfg_r.globalConfiguration :
    hitTim  ? cfg_r.bitTimingSetup :
    hitGmx  ? cfg_r.glbMaskExt :
    hitGmb  ? cfg_r.glbMaskBase :
    hitBmx  ? cfg_r.basMaskExt :
    hitBmb  ? cfg_r.basMaskBase :
    hitIen  ? irqEnable_r :
    hitIpnd ? irqPending_r :
    hitIcen ? irqCodeEn_r :
    hitCode ? {11'h000, irqFlag_r, irqCode_r} :
    hitErrc ? errCounters :
    hitDiag ? errDiag :
    hitTs   ? tsCount_r :
    16'h0000;

  // ----------------------------------------
  // Interrupt pending, enable and coding
  // ----------------------------------------
  // A number past buffer 14 must not land on the error flag
  wire logic        bufIrqOk = bufIrq && bufIrqNum != 4'hf;
  wire logic [15:0] setMask =
    ({15'h0000, bufIrqOk} << bufIrqNum) |
    (16'(errIrq) << cib_pkg::ERR_IRQ_BIT);
  wire logic [15:0] clrMask = wrIclr ? mergeBytes(16'h0000, cpuReq.wdata, cpuReq.byteEn)
                                     : 16'h0000;
  // Set wins over a clear in the same cycle
  assign irqPending_nxt = (irqPending_r & ~clrMask) | setMask;
  wire logic [15:0] codable = irqPending_r & irqEnable_r & irqCodeEn_r;

  logic [3:0] codeNxt;
  logic       flagNxt;
  always_comb begin
    codeNxt = cib_pkg::CODE_NONE;
    flagNxt = 1'b0;
    for (int i = cib_pkg::BUF_CNT - 1; i >= 0; i--) begin
      if (codable[i]) begin
        codeNxt = 4'(i + 1);
        flagNxt = 1'b1;
      end
    end
    if (codable[cib_pkg::ERR_IRQ_BIT]) begin
      codeNxt = cib_pkg::CODE_NONE;
      flagNxt = 1'b1;
    end
  end

  // ----------------------------------------
  // Timestamp counter
  // ----------------------------------------
  // Zeroing outranks a bit time in the same cycle; the stamp keeps the count
  wire logic tsSyncEn = cfg_r.globalConfiguration[cib_pkg::TS_SYNC_EN_BIT];
  wire logic tsZero   = msgDone && msgBuf == 4'h0 && tsSyncEn;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tsCount_r  <= cib_pkg::REG_RESET;
      ackStamp_r <= cib_pkg::REG_RESET;
    end else begin
      if (ackSlot) begin
        ackStamp_r <= tsCount_r;
      end
      if (tsZero) begin
        tsCount_r <= cib_pkg::REG_RESET;
      end else if (bitTick) begin
        tsCount_r <= tsCount_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Status and stamp words
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < cib_pkg::BUF_CNT; b++) begin
        statusW_r[b] <= cib_pkg::REG_RESET;
        stampW_r[b]  <= cib_pkg::REG_RESET;
      end
    end else begin
      if (cpuWrRam && cpuIsStat) begin
        statusW_r[cpuBank] <= cpuStatW;
      end
      if (engWrRam && engSlot == cib_pkg::SLOT_STATUS_CONTROL) begin
        statusW_r[engBank] <= engReq.wdata;
      end
      if (cpuWrRam && cpuSlot == cib_pkg::SLOT_CAPTURE_TIME) begin
        stampW_r[cpuBank] <= mergeBytes(stampW_r[cpuBank], cpuReq.wdata, cpuBeEff);
      end
      if (engWrRam && engSlot == cib_pkg::SLOT_CAPTURE_TIME) begin
        stampW_r[engBank] <= engReq.wdata;
      end
      if (msgDone && msgBuf != 4'hf) begin
        stampW_r[msgBuf] <= ackStamp_r;
      end
    end
  end

  // Data words carry no reset; software loads them before use
  always_ff @(posedge mclk) begin
    if (cpuWrRam && cpuSlot > cib_pkg::SLOT_CAPTURE_TIME) begin
      ram[{cpuBank, cpuSlot}] <= mergeBytes(ram[{cpuBank, cpuSlot}],
                                            cpuReq.wdata, cpuBeEff);
    end
    if (engWrRam && engSlot > cib_pkg::SLOT_CAPTURE_TIME) begin
      ram[engReq.addr] <= engReq.wdata;
    end
  end

  // ----------------------------------------
  // Registers and interrupt state
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r        <= '0;
      irqEnable_r  <= cib_pkg::REG_RESET;
      irqPending_r <= cib_pkg::REG_RESET;
      irqCodeEn_r  <= cib_pkg::REG_RESET;
      irqCode_r    <= cib_pkg::CODE_NONE;
      irqFlag_r    <= 1'b0;
    end else begin
      if (wrGcfg) cfg_r.globalConfiguration <=
        mergeBytes(cfg_r.globalConfiguration, cpuReq.wdata, cpuReq.byteEn);
      if (wrTim) cfg_r.bitTimingSetup <=
        mergeBytes(cfg_r.bitTimingSetup, cpuReq.wdata, cpuReq.byteEn);
      if (wrGmx) cfg_r.glbMaskExt <=
        mergeBytes(cfg_r.glbMaskExt, cpuReq.wdata, cpuReq.byteEn);
      if (wrGmb) cfg_r.glbMaskBase <=
        mergeBytes(cfg_r.glbMaskBase, cpuReq.wdata, cpuReq.byteEn);
      if (wrBmx) cfg_r.basMaskExt <=
        mergeBytes(cfg_r.basMaskExt, cpuReq.wdata, cpuReq.byteEn);
      if (wrBmb) cfg_r.basMaskBase <=
        mergeBytes(cfg_r.basMaskBase, cpuReq.wdata, cpuReq.byteEn);
      if (wrIen) irqEnable_r <=
        mergeBytes(irqEnable_r, cpuReq.wdata, cpuReq.byteEn);
      if (wrIcen) irqCodeEn_r <=
        mergeBytes(irqCodeEn_r, cpuReq.wdata, cpuReq.byteEn);
      irqPending_r <= irqPending_nxt;
      irqCode_r    <= codeNxt;
      irqFlag_r    <= flagNxt;
    end
  end

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lastCpu_r  <= 1'b0;
      cpuAck_r   <= 1'b0;
      engAck_r   <= 1'b0;
      cpuRData_r <= 16'h0000;
      engRData_r <= 16'h0000;
    end else begin
      if (clash) begin
        lastCpu_r <= cpuWins;
      end
      cpuAck_r <= cpuGo;
      engAck_r <= engGo;
      if (cpuGo && !cpuReq.write) begin
        cpuRData_r <= cpuRam ? cpuBufRd : regRd;
      end
      if (engGo && !engReq.write) begin
        engRData_r <= engBufRd;
      end
    end
  end

  assign cpuAck           = cpuAck_r;
  assign cpuRData         = cpuRData_r;
  assign engAck           = engAck_r;
  assign engRData         = engRData_r;
  assign cfgOut           = cfg_r;
  assign timestampCounter = tsCount_r;
  assign irqOut           = irqFlag_r;
endmodule : cib_can_core
`default_nettype wire

// ---- inc/cib_pkg.sv ----
// Constants, field layout and carriers for the CAN irq/timestamp/buffer block
`default_nettype none
package cib_pkg;
  // ----------------------------------------
  // Address map (absolute byte addresses)
  // ----------------------------------------
  localparam logic [19:0] CAN_BASE                 = 20'hef000;
  localparam logic [19:0] ADR_GLOBAL_CONFIGURATION = 20'hef100;
  localparam logic [19:0] ADR_BIT_TIMING_SETUP     = 20'hef102;
  localparam logic [19:0] ADR_GLB_MASK_EXT         = 20'hef104;
  localparam logic [19:0] ADR_GLB_MASK_BASE        = 20'hef106;
  localparam logic [19:0] ADR_BAS_MASK_EXT         = 20'hef108;
  localparam logic [19:0] ADR_BAS_MASK_BASE        = 20'hef10a;
  localparam logic [19:0] ADR_IRQ_ENABLE           = 20'hef10c;
  localparam logic [19:0] ADR_IRQ_PENDING          = 20'hef10e;
  localparam logic [19:0] ADR_IRQ_CLEAR            = 20'hef110;
  localparam logic [19:0] ADR_IRQ_CODE_ENABLE      = 20'hef112;
  localparam logic [19:0] ADR_STATUS_AND_IRQ_CODE  = 20'hef114;
  localparam logic [19:0] ADR_ERROR_COUNTERS       = 20'hef116;
  localparam logic [19:0] ADR_ERROR_DIAGNOSTIC     = 20'hef118;
  localparam logic [19:0] ADR_TIMESTAMP_COUNTER    = 20'hef11a;
  localparam int unsigned SPACE_WORDS    = 144;
  localparam int unsigned BUF_CNT        = 15;
  localparam int unsigned WORDS_PER_BUF  = 8;
  // ----------------------------------------
  // Word slots inside one buffer bank
  // ----------------------------------------
  localparam logic [2:0] SLOT_STATUS_CONTROL = 3'h0;
  localparam logic [2:0] SLOT_CAPTURE_TIME   = 3'h1;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned LEN_CODE_LSB   = 12;
  localparam int unsigned TX_PRIO_LSB    = 4;
  localparam int unsigned BUSY_BIT       = 0;
  localparam int unsigned ERR_IRQ_BIT    = 15;
  localparam int unsigned TS_SYNC_EN_BIT = 0;
  localparam int unsigned CODE_FLAG_BIT  = 4;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [3:0]  CODE_NONE      = 4'h0;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  byteEn;
    logic [19:0] addr;
    logic [15:0] wdata;
  } cib_cpu_req_s;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } cib_eng_req_s;
  typedef struct packed {
    logic [15:0] globalConfiguration;
    logic [15:0] bitTimingSetup;
    logic [15:0] glbMaskExt;
    logic [15:0] glbMaskBase;
    logic [15:0] basMaskExt;
    logic [15:0] basMaskBase;
  } cib_cfg_s;
endpackage : cib_pkg
`default_nettype wire

// ---- test/cib_eng_model.sv ----
// Behavioural model of the CAN engine side of the buffer RAM port
`timescale 1ns/1ps
`default_nettype none
module cib_eng_model (
  input  wire logic                   mclk,
  input  wire logic                   engAck,
  input  wire logic [15:0]            engRData,
  output var  cib_pkg::cib_eng_req_s  engReq
);
  int lost = 0;
  initial engReq = '0;
  // ----------------------------------------
  // One word access, held until acknowledged or 20 cycles pass
  // ----------------------------------------
  task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] wd,
                     output logic [15:0] rd);
    int n;
    @(posedge mclk);
    engReq <= '{1'b1, w, a, wd};
    for (n = 0; n < 20 && engAck !== 1'b1; n++) @(posedge mclk);
    rd = engRData;
    // Released lines show garbage, never the last value
    engReq <= '{1'b0, 1'b0, ~a, ~wd};
    if (n == 20) lost++;
  endtask : acc
endmodule : cib_eng_model
`default_nettype wire

// ---- test/cib_core_properties.sv ----
// Port-level assertions for the CAN irq, timestamp and buffer block
`timescale 1ns/1ps
`default_nettype none
module cib_core_properties (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire cib_pkg::cib_cpu_req_s cpuReq,
  input wire logic                  cpuAck,
  input wire logic [15:0]           cpuRData,
  input wire cib_pkg::cib_eng_req_s engReq,
  input wire logic                  engAck,
  input wire logic                  bitTick,
  input wire logic                  msgDone,
  input wire logic [3:0]            msgBuf,
  input wire logic                  bufIrq,
  input wire logic                  errIrq,
  input wire cib_pkg::cib_cfg_s     cfgOut,
  input wire logic [15:0]           timestampCounter,
  input wire logic                  irqOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire cpuNew = cpuReq.valid && !cpuAck;
  wire isReg  = cpuReq.addr[19:5] == 15'h7788;
  wire zeroIt = msgDone && msgBuf == 4'h0 && cfgOut.globalConfiguration[0];
  reg_ack_a: assert property (cpuNew && isReg |=> cpuAck)
    else $error("register access not answered next cycle");
  cpu_ack_bound_a: assert property (cpuNew |-> ##[1:3] cpuAck)
    else $error("cpu access stalled too long");
  eng_ack_bound_a: assert property (engReq.valid && !engAck |-> ##[1:3] engAck)
    else $error("engine access stalled too long");
  rdata_hold_a: assert property ($changed(cpuRData) |-> cpuAck)
    else $error("read data moved without an answer");
  ts_step_a: assert property (bitTick && !msgDone |=>
    timestampCounter == $past(timestampCounter) + 16'h1)
    else $error("timestamp did not step on a bit time");
  ts_hold_a: assert property (!bitTick && !zeroIt |=> $stable(timestampCounter))
    else $error("timestamp moved without a bit time");
  ts_sync_a: assert property (zeroIt |=> timestampCounter == 16'h0)
    else $error("timestamp not zeroed by buffer 0 message");
  irq_cause_a: assert property ($rose(irqOut) |-> $past(bufIrq, 2) || $past(errIrq, 2)
    || $past(cpuAck) || $past(cpuAck, 2))
    else $error("interrupt rose without a cause");
  cover property (irqOut && errIrq);
  cover property (engAck && cpuReq.valid);
  cover property (zeroIt);
endmodule : cib_core_properties
bind cib_can_core cib_core_properties chk (.mclk(mclk), .rst_n(rst_n), .cpuReq(cpuReq),
  .cpuAck(cpuAck), .cpuRData(cpuRData), .engReq(engReq), .engAck(engAck),
  .bitTick(bitTick), .msgDone(msgDone), .msgBuf(msgBuf), .bufIrq(bufIrq), .errIrq(errIrq),
  .cfgOut(cfgOut), .timestampCounter(timestampCounter), .irqOut(irqOut));
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the CAN irq, timestamp and buffer block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                  mclk = 1'b0;
  logic                  rst_n = 1'b0;
  cib_pkg::cib_cpu_req_s cpuReq = '0;
  cib_pkg::cib_eng_req_s engReq;
  cib_pkg::cib_cfg_s     cfgOut;
  logic                  cpuAck, engAck, irqOut;
  logic [15:0]           cpuRData, engRData, tsOut, q, d, engQ;
  logic [15:0]           errCnt = '0, errDg = '0, pend = '0, en = '0, cen = '0;
  logic [4:0]            ev = '0;
  logic [3:0]            evNum = '0;
  logic [15:0]           memM [int];
  int                    failures = 0, checkCount = 0;
  always #20 mclk = ~mclk;
  cib_can_core uut (.mclk(mclk), .rst_n(rst_n), .cpuReq(cpuReq), .cpuAck(cpuAck),
    .cpuRData(cpuRData), .engReq(engReq), .engAck(engAck), .engRData(engRData),
    .bitTick(ev[4]), .ackSlot(ev[2]), .msgDone(ev[3]), .msgBuf(evNum), .bufIrq(ev[0]),
    .bufIrqNum(evNum), .errIrq(ev[1]), .errCounters(errCnt), .errDiag(errDg),
    .cfgOut(cfgOut), .timestampCounter(tsOut), .irqOut(irqOut));
  cib_eng_model eng (.mclk(mclk), .engAck(engAck), .engRData(engRData), .engReq(engReq));
  // ----------------------------------------
  // Reference model and bus tasks
  // ----------------------------------------
  function automatic logic [15:0] expCode();
    logic [15:0] act;
    act = pend & en & cen;
    if (act[15]) return 16'h0010;
    for (int i = 0; i < 15; i++) if (act[i]) return 16'h0011 + 16'(i);
    return 16'h0000;
  endfunction : expCode
  function automatic logic [19:0] ba(input int b, input int s);
    return cib_pkg::CAN_BASE + 20'(b * 16 + s * 2);
  endfunction : ba
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cpu(input logic w, input logic [19:0] a, input logic [15:0] wd,
                     input logic [1:0] be);
    int n;
    @(posedge mclk);
    cpuReq <= '{1'b1, w, be, a, wd};
    for (n = 0; n < 20 && cpuAck !== 1'b1; n++) @(posedge mclk);
    q = cpuRData;
    cpuReq <= '{1'b0, 1'b0, 2'b00, ~a, ~wd};
    if (n == 20) begin
      failures++;
      give_verdict();
    end
  endtask : cpu
  task automatic wr(input logic [19:0] a, input logic [15:0] wd, input logic [1:0] be = 2'b11);
    cpu(1'b1, a, wd, be);
  endtask : wr
  task automatic rdChk(input logic [19:0] a, input logic [15:0] e);
    cpu(1'b0, a, 16'h0000, 2'b11);
    check(q, e);
  endtask : rdChk
  task automatic pulse(input int k, input logic [3:0] num);
    @(posedge mclk);
    ev <= 5'(1 << k);
    evNum <= num;
    @(posedge mclk);
    ev <= '0;
  endtask : pulse
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'ha633));
    errCnt <= 16'($urandom);
    errDg <= 16'($urandom);
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      d = i == 11 ? errCnt : i == 12 ? errDg : 16'h0000;
      rdChk(cib_pkg::ADR_GLOBAL_CONFIGURATION + 20'(2 * i), d);
    end
    rdChk(ba(9, 0), 16'h0000);
    rdChk(ba(9, 1), 16'h0000);
    rdChk(20'hef11c, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      d = 16'($urandom);
      wr(cib_pkg::ADR_GLOBAL_CONFIGURATION + 20'(2 * i), d);
      rdChk(cib_pkg::ADR_GLOBAL_CONFIGURATION + 20'(2 * i), d);
      check(cfgOut[95 - 16 * i -: 16], d);
    end
    wr(cib_pkg::ADR_IRQ_PENDING, 16'hffff);
    wr(20'hef11e, 16'hffff);
    rdChk(cib_pkg::ADR_IRQ_PENDING, 16'h0000);
    rdChk(cib_pkg::ADR_IRQ_CLEAR, 16'h0000);
    rdChk(20'hef11e, 16'h0000);
    $display("test register access done");
    en = 16'hffff;
    cen = 16'hffff;
    wr(cib_pkg::ADR_IRQ_ENABLE, en);
    wr(cib_pkg::ADR_IRQ_CODE_ENABLE, cen);
    for (int n = 14; n >= 0; n--) begin
      pulse(0, 4'(n));
      pend[n] = 1'b1;
      rdChk(cib_pkg::ADR_STATUS_AND_IRQ_CODE, expCode());
    end
    pulse(1, 4'h0);
    pend[15] = 1'b1;
    rdChk(cib_pkg::ADR_IRQ_PENDING, pend);
    rdChk(cib_pkg::ADR_STATUS_AND_IRQ_CODE, expCode());
    check(16'(irqOut), 16'h0001);
    // Handler style retargeting: error no longer coded
    cen = 16'h7fff;
    wr(cib_pkg::ADR_IRQ_CODE_ENABLE, cen);
    rdChk(cib_pkg::ADR_STATUS_AND_IRQ_CODE, expCode());
    en = 16'h7ffe;
    wr(cib_pkg::ADR_IRQ_ENABLE, en);
    rdChk(cib_pkg::ADR_STATUS_AND_IRQ_CODE, expCode());
    for (int k = 1; k < 17; k++) begin
      wr(cib_pkg::ADR_IRQ_CLEAR, 16'(1 << (k % 16)));
      pend[k % 16] = 1'b0;
      d = expCode();
      rdChk(cib_pkg::ADR_STATUS_AND_IRQ_CODE, d);
      check(16'(irqOut), {15'h0000, d[4]});
    end
    $display("test interrupt coding done");
    wr(cib_pkg::ADR_GLOBAL_CONFIGURATION, 16'h0000);
    d = 16'($urandom_range(24, 5));
    repeat (d) pulse(4, 4'h0);
    rdChk(cib_pkg::ADR_TIMESTAMP_COUNTER, d);
    check(tsOut, d);
    pulse(2, 4'h0);
    pulse(3, 4'h3);
    rdChk(ba(3, 1), d);
    pulse(2, 4'h0);
    pulse(3, 4'h0);
    rdChk(cib_pkg::ADR_TIMESTAMP_COUNTER, d);
    wr(cib_pkg::ADR_GLOBAL_CONFIGURATION, 16'h0001);
    repeat (3) pulse(4, 4'h0);
    d = d + 16'h0003;
    pulse(2, 4'h0);
    pulse(3, 4'h0);
    rdChk(ba(0, 1), d);
    rdChk(cib_pkg::ADR_TIMESTAMP_COUNTER, 16'h0000);
    check(tsOut, 16'h0000);
    $display("test timestamp done");
    for (int s = 2; s < 8; s++) begin
      memM[s] = 16'($urandom);
      wr(ba(5, s), memM[s]);
    end
    for (int s = 2; s < 8; s++) rdChk(ba(5, s), memM[s]);
    d = 16'($urandom);
    wr(ba(5, 4), d, 2'b10);
    rdChk(ba(5, 4), {d[15:8], memM[4][7:0]});
    wr(ba(5, 5), d, 2'b01);
    rdChk(ba(5, 5), {memM[5][15:8], d[7:0]});
    wr(ba(6, 2), 16'h1234);
    eng.acc(1'b1, 7'h30, 16'h000d, engQ);
    wr(ba(6, 2), 16'h5678);
    rdChk(ba(6, 2), 16'h1234);
    wr(ba(6, 0), 16'h5a72);
    rdChk(ba(6, 0), 16'h0073);
    eng.acc(1'b0, 7'h32, 16'h0000, engQ);
    check(engQ, 16'h1234);
    eng.acc(1'b1, 7'h30, 16'h0000, engQ);
    wr(ba(6, 2), 16'h5678);
    rdChk(ba(6, 2), 16'h5678);
    fork
      wr(ba(7, 2), 16'h3c3c);
      eng.acc(1'b1, 7'h3b, 16'hc3c3, engQ);
    join
    rdChk(ba(7, 3), 16'hc3c3);
    rdChk(ba(7, 2), 16'h3c3c);
    wr(ba(15, 2), 16'hffff);
    rdChk(ba(15, 2), 16'h0000);
    check(16'(eng.lost), 16'h0000);
    $display("test buffer ram done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
